// [inc/clock_output_select_pkg.sv]
/*
 * Constants, field layouts and carrier types for the clock output select block.
 * Assumes a 50 MHz reference clock and a plain register port with 8-bit addresses.
 */
package clock_output_select_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CMOS_CTRL_ADDR = 8'h04;
    localparam logic [7:0] SYSREF_CTRL_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0c;
    localparam logic [7:0] SYSREF_PERIOD_ADDR = 8'h10;

    // Auxiliary output control fields
    localparam int AUX_EN_BIT = 0;
    localparam int AUX_SRC_BIT = 1;
    localparam int AUX_DIV_LSB = 8;
    localparam int AUX_DIV_W = 8;

    // CMOS output control fields
    localparam int CMOS_OVR_BIT = 0;
    localparam int C_MODE_LSB = 1;
    localparam int D_MODE_LSB = 3;
    localparam int OVR_OUT_EN_BIT = 5;

    // System reference control fields
    localparam int SYSREF_SEL_LSB = 0;
    localparam int SYSREF_SEL_W = 4;
    localparam int SYSREF_DEPTH = 16;

    // Output function codes, shared by pins and mode fields
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_REF = 2'h1;
    localparam logic [1:0] MODE_HALF = 2'h2;
    localparam logic [1:0] MODE_QUARTER = 2'h3;

    // Reference phase counter; function changes land only at its wrap
    localparam int PHASE_W = 3;
    localparam logic [2:0] PHASE_LAST = 3'h7;
    localparam logic [2:0] PHASE_FIRST = 3'h0;

    // Synchronised pin bundle layout
    localparam int PIN_W = 6;
    localparam int PIN_SYSREF = 0;
    localparam int PIN_PLL_EN = 1;
    localparam int PIN_PD = 2;
    localparam int PIN_CFG_LSB = 3;
    localparam int PIN_TS = 5;
    localparam logic [5:0] PIN_RESET = 6'h00;

    typedef struct packed {
        logic enable;
        logic from_serializer;
        logic [7:0] divider;
    } aux_cfg_type;

    typedef struct packed {
        logic override;
        logic [1:0] c_mode;
        logic [1:0] d_mode;
        logic overrange_en;
    } cmos_cfg_type;

    localparam aux_cfg_type AUX_CFG_RESET = '{enable: 1'b0, from_serializer: 1'b0,
                                              divider: 8'h04};
    localparam cmos_cfg_type CMOS_CFG_RESET = '{override: 1'b0, c_mode: 2'h0,
                                                d_mode: 2'h0, overrange_en: 1'b0};
    localparam logic [3:0] SYSREF_SEL_RESET = 4'h0;

endpackage : clock_output_select_pkg

// [verilog/pin_synchronizer.sv]
/*
 * Three-stage synchroniser for a bundle of asynchronous pins.
 * Assumes each bit is independent; a new level is taken once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_synchronizer #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
        end else begin
            stage1_reg <= pin_i;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Per bit, accept only a level seen on two consecutive samples
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            level_o <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_o[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule : pin_synchronizer

`default_nettype wire

// [verilog/lane_clock_divider.sv]
/*
 * Divides the serial lane bit rate, given as one strobe per lane bit, by a programmable ratio.
 * Assumes the strobe is on the local clock; ratios below two behave as two.
 */
`timescale 1ns/1ps
`default_nettype none

module lane_clock_divider #(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic strobe_i,
    input wire logic [DIV_W-1:0] divider_i,
    output logic clk_o
);

    logic [DIV_W-1:0] eff_div;
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;

    always_comb begin
        eff_div = (divider_i < DIV_W'(2)) ? DIV_W'(2) : divider_i;
        cnt_next = (cnt_reg >= eff_div - DIV_W'(1)) ? '0 : cnt_reg + DIV_W'(1);
    end

    // One output period per eff_div strobes, high for the first half
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            clk_o <= 1'b0;
        end else if (strobe_i) begin
            cnt_reg <= cnt_next; // RULE_03
            clk_o <= cnt_next < (eff_div >> 1);
        end
    end

    a_divider_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
        strobe_i && cnt_reg == eff_div - DIV_W'(1) |=> cnt_reg == '0 && clk_o)
        else $error("divider did not wrap after the last strobe of a period");

    a_divider_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
        !strobe_i |=> $stable(clk_o) && $stable(cnt_reg))
        else $error("divider moved without a lane strobe");

endmodule : lane_clock_divider

`default_nettype wire

// [verilog/clock_output_select.sv]
/*
 * Auxiliary clock output selection and division: one auxiliary output from timestamp or
 * lane clock, a reference copy, two CMOS outputs with pin or register function, and
 * windowed capture of the system reference.
 * Assumes one 50 MHz clock; pins are asynchronous, lane strobe and over-range flags are local.
 */
// Contract
// [RULE_01] Auxiliary output from timestamp or lane clock
// [RULE_02] Auxiliary output off until software enables it
// [RULE_03] Lane-sourced auxiliary output is rate over divider
// [RULE_04] CMOS outputs run from power-up by pins
// [RULE_05] Power-down pin silences both CMOS outputs
// [RULE_06] System keeps power-down low when needing clocks
// [RULE_07] Pins set C divider, only enable D
// [RULE_08] Override takes functions from mode fields
// [RULE_09] C: off/over-range, reference, half, quarter
// [RULE_10] D: pins off or reference; override all four
// [RULE_11] D divided only while C function nonzero
// [RULE_12] Clock function beats over-range flag
// [RULE_13] System reference pulse or periodic accepted
// [RULE_14] 8b/10b periodic reference frequency constraint
// [RULE_15] 64b/66b periodic reference frequency constraint
// [RULE_16] Reference captured on deterministic clock edge
// [RULE_17] Adjustable sampling window replaces setup/hold
// [RULE_18] Reference copy only with converter PLL enabled
// [RULE_19] Function changes land without runt pulses
`timescale 1ns/1ps
`default_nettype none

module clock_output_select #(
    parameter int SYSREF_DEPTH = clock_output_select_pkg::SYSREF_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    input wire logic timestamp_input_i,
    input wire logic lane_bit_strobe_i,
    input wire logic [1:0] clock_config_pins_i,
    input wire logic power_down_pin_i,
    input wire logic converter_pll_enable_i,
    input wire logic overrange_c_i,
    input wire logic overrange_d_i,
    input wire logic sysref_i,
    output logic aux_lvds_clock_out_o,
    output logic reference_clock_out_o,
    output logic cmos_clock_out_c_o,
    output logic cmos_clock_out_d_o,
    output logic sysref_capture_o
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [5:0] pin_bus;
    logic [5:0] pin_sync;
    logic ts_sync;
    logic [1:0] cfg_sync;
    logic pd_sync;
    logic pll_en_sync;
    logic sysref_sync;

    assign pin_bus = {timestamp_input_i, clock_config_pins_i, power_down_pin_i,
                      converter_pll_enable_i, sysref_i};

    pin_synchronizer #(
        .WIDTH(clock_output_select_pkg::PIN_W),
        .RESET_VAL(clock_output_select_pkg::PIN_RESET)
    ) pin_synchronizer_i (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(pin_bus),
        .level_o(pin_sync)
    );

    assign ts_sync = pin_sync[clock_output_select_pkg::PIN_TS];
    assign cfg_sync = pin_sync[clock_output_select_pkg::PIN_CFG_LSB +: 2];
    assign pd_sync = pin_sync[clock_output_select_pkg::PIN_PD];
    assign pll_en_sync = pin_sync[clock_output_select_pkg::PIN_PLL_EN];
    assign sysref_sync = pin_sync[clock_output_select_pkg::PIN_SYSREF];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Software registers

    clock_output_select_pkg::aux_cfg_type aux_cfg_reg;
    clock_output_select_pkg::cmos_cfg_type cmos_cfg_reg;
    logic [3:0] sysref_sel_reg;

    // Auxiliary output starts disabled and changes only on a software write
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aux_cfg_reg <= clock_output_select_pkg::AUX_CFG_RESET; // RULE_02
        end else if (reg_write_i && reg_addr_i == clock_output_select_pkg::AUX_CTRL_ADDR) begin
            aux_cfg_reg.enable <= reg_wdata_i[clock_output_select_pkg::AUX_EN_BIT];
            aux_cfg_reg.from_serializer <= reg_wdata_i[clock_output_select_pkg::AUX_SRC_BIT];
            aux_cfg_reg.divider <= reg_wdata_i[clock_output_select_pkg::AUX_DIV_LSB +:
                                               clock_output_select_pkg::AUX_DIV_W];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmos_cfg_reg <= clock_output_select_pkg::CMOS_CFG_RESET;
        end else if (reg_write_i &&
                     reg_addr_i == clock_output_select_pkg::CMOS_CTRL_ADDR) begin
            cmos_cfg_reg.override <= reg_wdata_i[clock_output_select_pkg::CMOS_OVR_BIT];
            cmos_cfg_reg.c_mode <= reg_wdata_i[clock_output_select_pkg::C_MODE_LSB +: 2];
            cmos_cfg_reg.d_mode <= reg_wdata_i[clock_output_select_pkg::D_MODE_LSB +: 2];
            cmos_cfg_reg.overrange_en <= reg_wdata_i[clock_output_select_pkg::OVR_OUT_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sysref_sel_reg <= clock_output_select_pkg::SYSREF_SEL_RESET;
        end else if (reg_write_i &&
                     reg_addr_i == clock_output_select_pkg::SYSREF_CTRL_ADDR) begin
            sysref_sel_reg <= reg_wdata_i[clock_output_select_pkg::SYSREF_SEL_LSB +:
                                          clock_output_select_pkg::SYSREF_SEL_W]; // RULE_17
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Auxiliary LVDS output

    logic lane_div_clk;
    logic aux_src_val;

    lane_clock_divider #(
        .DIV_W(clock_output_select_pkg::AUX_DIV_W)
    ) lane_clock_divider_i (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .strobe_i(lane_bit_strobe_i),
        .divider_i(aux_cfg_reg.divider),
        .clk_o(lane_div_clk)
    );

    assign aux_src_val = aux_cfg_reg.from_serializer ? lane_div_clk : ts_sync; // RULE_01 RULE_03

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aux_lvds_clock_out_o <= 1'b0;
        end else begin
            aux_lvds_clock_out_o <= aux_cfg_reg.enable & aux_src_val; // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reference phase and function selection for the CMOS outputs

    logic [2:0] phase_reg;
    logic [1:0] c_mode_next;
    logic [1:0] d_mode_pick;
    logic [1:0] d_mode_next;
    logic [1:0] c_mode_reg;
    logic [1:0] d_mode_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_reg <= clock_output_select_pkg::PHASE_FIRST;
        end else begin
            phase_reg <= phase_reg + 3'h1;
        end
    end

    always_comb begin
        c_mode_next = cmos_cfg_reg.override ? cmos_cfg_reg.c_mode : cfg_sync; // RULE_08 RULE_09
        if (cmos_cfg_reg.override) begin
            d_mode_pick = cmos_cfg_reg.d_mode; // RULE_08 RULE_10
        end else if (cfg_sync == clock_output_select_pkg::MODE_OFF) begin
            d_mode_pick = clock_output_select_pkg::MODE_OFF; // RULE_07
        end else begin
            d_mode_pick = clock_output_select_pkg::MODE_REF; // RULE_07 RULE_10
        end
        if (d_mode_pick >= clock_output_select_pkg::MODE_HALF &&
            c_mode_next == clock_output_select_pkg::MODE_OFF) begin
            d_mode_next = clock_output_select_pkg::MODE_OFF; // RULE_11
        end else begin
            d_mode_next = d_mode_pick;
        end
    end

    // Functions switch only as the phase wraps, when every candidate clock is high and
    // the next sample of each is low, so no shortened pulse reaches the pin
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            c_mode_reg <= clock_output_select_pkg::MODE_OFF;
            d_mode_reg <= clock_output_select_pkg::MODE_OFF;
        end else if (phase_reg == clock_output_select_pkg::PHASE_LAST) begin
            c_mode_reg <= c_mode_next; // RULE_19 RULE_04
            d_mode_reg <= d_mode_next; // RULE_19
        end
    end

    function automatic logic pick_output(input logic [1:0] mode, input logic [2:0] phase,
                                         input logic overrange_output_enable, input logic ovr_flag);
        logic result;
        result = 1'b0;
        unique case (mode)
            clock_output_select_pkg::MODE_OFF: result = overrange_output_enable & ovr_flag;
            clock_output_select_pkg::MODE_REF: result = phase[0];
            clock_output_select_pkg::MODE_HALF: result = phase[1];
            clock_output_select_pkg::MODE_QUARTER: result = phase[2];
        endcase
        return result;
    endfunction : pick_output

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmos_clock_out_c_o <= 1'b0;
        end else if (pd_sync) begin
            cmos_clock_out_c_o <= 1'b0; // RULE_05
        end else begin
            cmos_clock_out_c_o <= pick_output(c_mode_reg, phase_reg,
                                              cmos_cfg_reg.overrange_en,
                                              overrange_c_i); // RULE_09 RULE_12
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmos_clock_out_d_o <= 1'b0;
        end else if (pd_sync) begin
            cmos_clock_out_d_o <= 1'b0; // RULE_05
        end else begin
            cmos_clock_out_d_o <= pick_output(d_mode_reg, phase_reg,
                                              cmos_cfg_reg.overrange_en,
                                              overrange_d_i); // RULE_10 RULE_12
        end
    end

    // Reference copy runs only with the converter PLL on and the part powered
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reference_clock_out_o <= 1'b0;
        end else begin
            reference_clock_out_o <= pll_en_sync & ~pd_sync & phase_reg[0]; // RULE_18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // System reference windowed capture

    logic [SYSREF_DEPTH-1:0] sysref_line_reg;
    logic sysref_delayed;
    logic sysref_prev_reg;
    logic sysref_rise;
    logic [7:0] sysref_count_reg;
    logic [15:0] sysref_gap_reg;
    logic [15:0] sysref_period_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sysref_line_reg <= '0;
            sysref_prev_reg <= 1'b0;
        end else begin
            sysref_line_reg <= {sysref_line_reg[SYSREF_DEPTH-2:0], sysref_sync};
            sysref_prev_reg <= sysref_delayed;
        end
    end

    assign sysref_delayed = sysref_line_reg[sysref_sel_reg]; // RULE_17
    assign sysref_rise = sysref_delayed & ~sysref_prev_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sysref_capture_o <= 1'b0;
        end else begin
            sysref_capture_o <= sysref_rise; // RULE_16
        end
    end

    // Every rising edge is taken, so one pulse and a periodic train both work
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sysref_count_reg <= 8'h00;
            sysref_gap_reg <= 16'h0000;
            sysref_period_reg <= 16'h0000;
        end else if (sysref_rise) begin
            sysref_count_reg <= sysref_count_reg + 8'h01; // RULE_13
            sysref_gap_reg <= 16'h0000;
            sysref_period_reg <= sysref_gap_reg + 16'h0001; // RULE_14 RULE_15
        end else if (sysref_gap_reg != 16'hffff) begin
            sysref_gap_reg <= sysref_gap_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register read port

    logic [31:0] status_word;

    assign status_word = {16'h0000, sysref_count_reg, d_mode_reg, c_mode_reg,
                          pll_en_sync, pd_sync, cfg_sync};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_read_i) begin
            unique case (reg_addr_i)
                clock_output_select_pkg::AUX_CTRL_ADDR:
                    reg_rdata_o <= {16'h0000, aux_cfg_reg.divider, 6'h00,
                                    aux_cfg_reg.from_serializer, aux_cfg_reg.enable};
                clock_output_select_pkg::CMOS_CTRL_ADDR:
                    reg_rdata_o <= {26'h0000000, cmos_cfg_reg.overrange_en,
                                    cmos_cfg_reg.d_mode, cmos_cfg_reg.c_mode,
                                    cmos_cfg_reg.override};
                clock_output_select_pkg::SYSREF_CTRL_ADDR:
                    reg_rdata_o <= {28'h0000000, sysref_sel_reg};
                clock_output_select_pkg::STATUS_ADDR:
                    reg_rdata_o <= status_word;
                clock_output_select_pkg::SYSREF_PERIOD_ADDR:
                    reg_rdata_o <= {16'h0000, sysref_period_reg};
                default:
                    reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb_main @(posedge ref_clk_i);
    endclocking

    default disable iff (rst_i);

    sequence s_delayed_rise;
        !sysref_delayed ##1 sysref_delayed;
    endsequence

    a_aux_disabled_low: assert property ( // RULE_02
        !aux_cfg_reg.enable |=> !aux_lvds_clock_out_o)
        else $error("auxiliary output active while disabled");

    a_aux_timestamp_path: assert property ( // RULE_01
        aux_cfg_reg.enable && !aux_cfg_reg.from_serializer |=>
            aux_lvds_clock_out_o == $past(ts_sync))
        else $error("auxiliary output does not follow timestamp");

    a_aux_lane_path: assert property ( // RULE_03
        aux_cfg_reg.enable && aux_cfg_reg.from_serializer |=>
            aux_lvds_clock_out_o == $past(lane_div_clk))
        else $error("auxiliary output does not follow divided lane clock");

    a_power_down_quiet: assert property ( // RULE_05
        pd_sync |=> !cmos_clock_out_c_o && !cmos_clock_out_d_o)
        else $error("CMOS output active during power-down");

    a_reference_pll_gate: assert property ( // RULE_18
        !pll_en_sync |=> !reference_clock_out_o)
        else $error("reference copy active with converter PLL off");

    a_mode_change_wrap: assert property ( // RULE_19
        $changed(c_mode_reg) || $changed(d_mode_reg) |->
            phase_reg == clock_output_select_pkg::PHASE_FIRST ##1
            (c_mode_reg == clock_output_select_pkg::MODE_OFF || !cmos_clock_out_c_o) &&
            (d_mode_reg == clock_output_select_pkg::MODE_OFF || !cmos_clock_out_d_o))
        else $error("output function changed away from the phase wrap");

    a_d_divided_needs_c: assert property ( // RULE_11
        d_mode_reg >= clock_output_select_pkg::MODE_HALF |->
            c_mode_reg != clock_output_select_pkg::MODE_OFF)
        else $error("output D divided while output C is off");

    a_c_follows_pins: assert property ( // RULE_08
        phase_reg == clock_output_select_pkg::PHASE_LAST && !cmos_cfg_reg.override |=>
            c_mode_reg == $past(cfg_sync))
        else $error("output C function does not follow the pins");

    a_d_pins_reference: assert property ( // RULE_07
        phase_reg == clock_output_select_pkg::PHASE_LAST && !cmos_cfg_reg.override &&
            cfg_sync != clock_output_select_pkg::MODE_OFF |=>
            d_mode_reg == clock_output_select_pkg::MODE_REF)
        else $error("output D pin function is not the plain reference");

    a_overrange_flag: assert property ( // RULE_12
        c_mode_reg == clock_output_select_pkg::MODE_OFF && !pd_sync |=>
            cmos_clock_out_c_o == $past(cmos_cfg_reg.overrange_en & overrange_c_i))
        else $error("output C over-range flag path wrong");

    a_sysref_capture: assert property ( // RULE_16
        s_delayed_rise |=> sysref_capture_o ##1 !sysref_capture_o)
        else $error("system reference edge not captured for exactly one cycle");

endmodule : clock_output_select

`default_nettype wire

// [testbench/far_side_model.sv]
/*
 * Far-side logic model: lane bit strobes and a periodic system reference.
 * Assumes the same clock as the block; period 0 keeps the reference low.
 */
`timescale 1ns/1ps
`default_nettype none

module far_side_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] period_i,
    output logic strobe_o = 1'b0,
    output logic sysref_o = 1'b0
);
    logic [7:0] cnt_reg = 8'h00;

    always @(posedge ref_clk_i) begin
        strobe_o <= 1'b1;
        cnt_reg <= (cnt_reg + 8'h01 >= period_i) ? 8'h00 : cnt_reg + 8'h01;
        // Two cycles wide so the pin filter of the block keeps the pulse
        sysref_o <= (period_i != 8'h00) && (cnt_reg < 8'h02);
    end
endmodule : far_side_model
`default_nettype wire

// [testbench/test_clock_output_select.sv]
/*
 * Testbench for the clock output select block: register tasks and output edge counts.
 * Assumes the far-side model for lane strobes and system reference.
 */
`timescale 1ns/1ps
`default_nettype none

module test_clock_output_select;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic we = 1'b0, rd = 1'b0, ts = 1'b0, pd = 1'b0, pll = 1'b1, oc = 1'b0, od = 1'b0;
    logic [1:0] cfg = 2'h1;
    logic [7:0] per = 8'h00;
    logic [31:0] rdata;
    logic strobe, sysref, aux, refo, outc, outd, cap;
    int errors = 0, checked = 0, n, m;
    int rise_tab[4] = '{0, 16, 8, 4};

    always #10 ref_clk_i = ~ref_clk_i;

    far_side_model far_side_model_i (.ref_clk_i(ref_clk_i), .period_i(per), .strobe_o(strobe),
        .sysref_o(sysref));
    clock_output_select clock_output_select_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(we), .reg_read_i(rd),
        .reg_rdata_o(rdata), .timestamp_input_i(ts), .lane_bit_strobe_i(strobe),
        .clock_config_pins_i(cfg), .power_down_pin_i(pd), .converter_pll_enable_i(pll),
        .overrange_c_i(oc), .overrange_d_i(od), .sysref_i(sysref),
        .aux_lvds_clock_out_o(aux), .reference_clock_out_o(refo), .cmos_clock_out_c_o(outc),
        .cmos_clock_out_d_o(outd), .sysref_capture_o(cap));

    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge ref_clk_i);
        we <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1 chk(rdata, exp, "read data");
    endtask : rd_chk

    function automatic logic pick(input int s);
        return s == 0 ? outc : s == 1 ? outd : s == 2 ? refo : aux;
    endfunction : pick

    // Rising edges and high cycles over 32 cycles, phase independent
    task meas(input int s, input int er, input int eh);
        logic prev;
        int nr;
        int nh;
        nr = 0;
        nh = 0;
        @(negedge ref_clk_i);
        prev = pick(s);
        repeat (32) begin
            @(negedge ref_clk_i);
            if (pick(s) === 1'b1 && prev === 1'b0) nr++;
            if (pick(s) === 1'b1) nh++;
            prev = pick(s);
        end
        chk(32'(nr), 32'(er), "rises");
        chk(32'(nh), 32'(eh), "highs");
        @(posedge ref_clk_i);
    endtask : meas

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        rd_chk(8'h0c, 32'h0000_0059);
        rd_chk(8'h00, 32'h0000_0400);
        rd_chk(8'h14, 32'h0);
        meas(3, 0, 0);
        meas(0, 16, 16);
        for (n = 0; n < 4; n++) begin
            cfg <= 2'(n);
            repeat (16) @(posedge ref_clk_i);
            meas(0, rise_tab[n], n == 0 ? 0 : 16);
            meas(1, n == 0 ? 0 : 16, n == 0 ? 0 : 16);
        end
        pd <= 1'b1;
        repeat (16) @(posedge ref_clk_i);
        meas(0, 0, 0);
        meas(1, 0, 0);
        pd <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        meas(2, 16, 16);
        pll <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        meas(2, 0, 0);
        for (n = 0; n < 4; n++) begin
            wr(8'h04, 32'h1 | 32'(n) << 1 | 32'(n) << 3);
            meas(0, rise_tab[n], n == 0 ? 0 : 16);
            meas(1, rise_tab[n], n == 0 ? 0 : 16);
        end
        wr(8'h04, 32'h0000_0011);
        meas(1, 0, 0);
        oc <= 1'b1;
        od <= 1'b1;
        wr(8'h04, 32'h0000_0023);
        meas(0, 16, 16);
        meas(1, 0, 32);
        rd_chk(8'h04, 32'h0000_0023);
        for (n = 2; n <= 8; n = n * 2) begin
            wr(8'h00, 32'h3 | 32'(n) << 8);
            meas(3, 32 / n, 16);
        end
        ts <= 1'b1;
        wr(8'h00, 32'h0000_0001);
        meas(3, 0, 32);
        per <= 8'h28;
        m = 0;
        for (n = 0; n < 100 && m == 0; n++) begin
            @(negedge ref_clk_i);
            if (cap === 1'b1) m = 1;
        end
        chk(32'(m), 32'h1, "capture");
        repeat (100) @(posedge ref_clk_i);
        rd_chk(8'h10, 32'h0000_0028);
        wr(8'h08, 32'h0000_0005);
        rd_chk(8'h08, 32'h0000_0005);
        report_and_stop();
    end
endmodule : test_clock_output_select
`default_nettype wire
